/* hdl/timeout_cfg_pkg.sv */
// Constants, register map and types for the timeout timer logical device
package timeout_cfg_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES_DFLT = TICK_PERIOD_NS / CLK_PERIOD_NS;

  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 11;
  localparam int unsigned ADDR_HI_LSB = 12;
  localparam int unsigned HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  localparam logic [9:0] IDX_ACTIVATE = 10'h030;
  localparam logic [9:0] IDX_BASE_HIGH = 10'h060;
  localparam logic [9:0] IDX_BASE_LOW = 10'h061;
  localparam logic [9:0] IDX_INT_SELECT = 10'h070;
  localparam logic [9:0] IDX_INT_TYPE = 10'h071;
  localparam logic [9:0] IDX_DMA_REPORT0 = 10'h074;
  localparam logic [9:0] IDX_DMA_REPORT1 = 10'h075;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0F8;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0F9;
  localparam logic [9:0] IDX_TIMER_CONFIG = 10'h0F0;
  localparam logic [9:0] IDX_TMR_RELOAD = 10'h100;
  localparam logic [9:0] IDX_TMR_SERVICE = 10'h101;
  localparam logic [9:0] IDX_TMR_COUNT = 10'h102;
  localparam logic [9:0] IDX_RUNTIME_BASE = 10'h100;

  localparam int unsigned ACT_BIT = 0;
  localparam int unsigned CFG_TRI_BIT = 0;
  localparam int unsigned CFG_PM_BIT = 1;
  localparam int unsigned CFG_PU_BIT = 2;
  localparam int unsigned CFG_OT_BIT = 3;
  localparam int unsigned INTTYPE_LVL_BIT = 1;
  localparam int unsigned ROUTE_SEL_MSB = 3;
  localparam int unsigned WAKE_BIT = 4;
  localparam int unsigned STAT_TIMEOUT_BIT = 0;

  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h02;
  localparam logic [7:0] CFG_WMASK = 8'h0F;
  localparam logic [7:0] BASELO_WMASK = 8'hFC;
  localparam logic [7:0] INTTYPE_RESET = 8'h03;
  localparam logic [7:0] INTTYPE_FIXED = 8'h01;
  localparam logic [7:0] DMA_NONE = 8'h04;
  localparam logic [7:0] STAT_WMASK = 8'h01;
  localparam logic [7:0] TMR_ONE = 8'h01;

  typedef enum {BUS_IDLE, BUS_WRITE, BUS_READ} bus_phase_t;
endpackage : timeout_cfg_pkg

/* hdl/tmr_if.sv */
// Control and status bundle between the register bank and the timer unit
`timescale 1ns/1ps
`default_nettype none
interface tmr_if;
  logic run;
  logic kick;
  logic [7:0] reload;
  logic [7:0] count;
  logic expired;
  logic timeout;
  modport ctrl (output run, output kick, output reload, input count, input expired, input timeout);
  modport unit (input run, input kick, input reload, output count, output expired, output timeout);
endinterface : tmr_if
`default_nettype wire

/* hdl/timeout_timer_unit.sv */
// Down-counting timeout timer with tick prescaler
`timescale 1ns/1ps
`default_nettype none
module timeout_timer_unit
  import timeout_cfg_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
)
(
  input wire logic mclk,
  input wire logic srst,
  tmr_if.unit tif
);
  logic [31:0] presc_r;
  logic tick;
  logic [7:0] count_r;
  logic expired_r;
  logic timeout_r;

  assign tick = tif.run && (presc_r == 32'(TICK_CYCLES - 1));
  assign tif.count = count_r;
  assign tif.expired = expired_r;
  assign tif.timeout = timeout_r;

  // Stopped clock: prescaler restarts, count is kept unless a service write reloads it
  always_ff @(posedge mclk)
  begin
    if (srst || !tif.run || tick)
      presc_r <= '0;
    else
      presc_r <= presc_r + 32'h00000001;
  end

  // Count stays at zero until the first service write arms it
  always_ff @(posedge mclk)
  begin
    if (srst)
      count_r <= ZERO8;
    else if (tif.kick)
      count_r <= tif.reload;
    else if (tick && count_r != ZERO8)
      count_r <= count_r - TMR_ONE;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      expired_r <= 1'b0;
      timeout_r <= 1'b0;
    end
    else
    begin
      expired_r <= tick && !tif.kick && count_r == TMR_ONE;
      if (tif.kick)
        timeout_r <= 1'b0;
      else if (tick && count_r == TMR_ONE)
        timeout_r <= 1'b1;
    end
  end

  a_stopped_holds: assert property (@(posedge mclk) disable iff (srst)
    (!tif.run && !tif.kick) |=> $stable(count_r))
    else $error("count moved while timer clock stopped");
  a_expiry_flag: assert property (@(posedge mclk) disable iff (srst)
    (tick && !tif.kick && count_r == TMR_ONE) |=> (expired_r && timeout_r && count_r == ZERO8))
    else $error("expiry not flagged");
endmodule : timeout_timer_unit
`default_nettype wire

/* hdl/timeout_pin_driver.sv */
// Output stage of the timeout pin: driver type, pull-up and floating
`timescale 1ns/1ps
`default_nettype none
module timeout_pin_driver
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic want_low,
  input wire logic push_pull,
  input wire logic pullup_req,
  input wire logic float_req,
  output logic pin_o,
  output logic pin_oe_n,
  output logic pullup_en
);
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pin_o <= 1'b1;
      pin_oe_n <= 1'b1;
      pullup_en <= 1'b0;
    end
    else
    begin
      pullup_en <= pullup_req;
      if (float_req)
      begin
        pin_o <= 1'b1;
        pin_oe_n <= 1'b1;
      end
      else if (push_pull)
      begin
        pin_o <= !want_low;
        pin_oe_n <= 1'b0;
      end
      else
      begin
        // Open-drain only ever drives low
        pin_o <= 1'b0;
        pin_oe_n <= !want_low;
      end
    end
  end

  a_float_pin: assert property (@(posedge mclk) disable iff (srst)
    float_req |=> (pin_oe_n && pin_o))
    else $error("pin not floated");
  a_drive_kind: assert property (@(posedge mclk) disable iff (srst)
    (!float_req && push_pull) |=> (!pin_oe_n && pin_o == !$past(want_low)))
    else $error("push-pull not driving");
  a_pullup_follow: assert property (@(posedge mclk) disable iff (srst)
    pullup_req ##1 pullup_req |-> pullup_en)
    else $error("pull-up not enabled");
endmodule : timeout_pin_driver
`default_nettype wire

/* hdl/timeout_timer_ldev.sv */
// Timeout timer logical device: AHB-Lite register bank, timer and pin
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module timeout_timer_ldev
  import timeout_cfg_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
)
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  output logic [3:0] irq_route_sel,
  output logic irq_wake_en,
  output logic irq_type_level,
  output logic timeout_pin_o,
  output logic timeout_pin_oe_n,
  output logic timeout_pullup_en
);
  bus_phase_t phase_r;
  logic [9:0] idx_r;
  logic addr_ok_r;
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  logic accept;
  logic wr_ok;
  logic rd_en;
  logic [7:0] rd_val;
  logic [7:0] wdat;

  logic activate_r;
  logic [7:0] base_hi_r;
  logic [7:0] base_lo_r;
  logic [7:0] intsel_r;
  logic inttype_r;
  logic [7:0] cfg_r;
  logic [7:0] reload_r;
  logic [7:0] mask_r;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic kick_r;
  logic irq_r;
  logic want_low;
  logic float_req;

  tmr_if tif ();

  function automatic logic is_runtime(input logic [9:0] idx);
    is_runtime = (idx >= IDX_RUNTIME_BASE);
  endfunction : is_runtime

  assign accept = hsel && htrans[HTRANS_ACTIVE_BIT] && hreadyout_r;
  assign rd_en = (phase_r == BUS_READ);
  assign wdat = hwdata[7:0];
  // Word accesses only; hsize is not checked
  assign wr_ok = (phase_r == BUS_WRITE) && addr_ok_r && (!is_runtime(idx_r) || activate_r);

  // Reads take one wait state so a write just before is already visible
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      phase_r <= BUS_IDLE;
      idx_r <= '0;
      addr_ok_r <= 1'b0;
      hreadyout_r <= 1'b1;
    end
    else
    begin
      case (phase_r)
        BUS_IDLE, BUS_WRITE:
        begin
          if (accept)
          begin
            phase_r <= hwrite ? BUS_WRITE : BUS_READ;
            idx_r <= haddr[IDX_MSB:IDX_LSB];
            addr_ok_r <= (haddr[31:ADDR_HI_LSB] == '0);
            hreadyout_r <= hwrite;
          end
          else
            phase_r <= BUS_IDLE;
        end
        BUS_READ:
        begin
          phase_r <= BUS_IDLE;
          hreadyout_r <= 1'b1;
        end
        default:
        begin
          phase_r <= BUS_IDLE;
          hreadyout_r <= 1'b1;
        end
      endcase
    end
  end

  always_comb
  begin
    rd_val = ZERO8;
    if (addr_ok_r && (!is_runtime(idx_r) || activate_r))
    begin
      case (idx_r)
        IDX_ACTIVATE: rd_val = {7'h00, activate_r};
        IDX_BASE_HIGH: rd_val = base_hi_r;
        IDX_BASE_LOW: rd_val = base_lo_r & BASELO_WMASK;
        IDX_INT_SELECT: rd_val = intsel_r;
        IDX_INT_TYPE: rd_val = INTTYPE_FIXED | {6'h00, inttype_r, 1'b0};
        IDX_DMA_REPORT0, IDX_DMA_REPORT1: rd_val = DMA_NONE;
        IDX_TIMER_CONFIG: rd_val = cfg_r & CFG_WMASK;
        IDX_IRQ_STATUS: rd_val = status_r;
        IDX_IRQ_MASK: rd_val = mask_r;
        IDX_TMR_RELOAD: rd_val = reload_r;
        IDX_TMR_COUNT: rd_val = tif.count;
        default: rd_val = ZERO8;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      hrdata_r <= '0;
    else if (rd_en)
      hrdata_r <= {24'h000000, rd_val};
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      activate_r <= 1'b0;
    else if (wr_ok && idx_r == IDX_ACTIVATE)
      activate_r <= wdat[ACT_BIT];
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      base_hi_r <= ZERO8;
      base_lo_r <= ZERO8;
    end
    else
    begin
      if (wr_ok && idx_r == IDX_BASE_HIGH)
        base_hi_r <= wdat;
      if (wr_ok && idx_r == IDX_BASE_LOW)
        base_lo_r <= wdat & BASELO_WMASK;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      intsel_r <= ZERO8;
      inttype_r <= INTTYPE_RESET[INTTYPE_LVL_BIT];
    end
    else
    begin
      if (wr_ok && idx_r == IDX_INT_SELECT)
        intsel_r <= wdat;
      if (wr_ok && idx_r == IDX_INT_TYPE)
        inttype_r <= wdat[INTTYPE_LVL_BIT];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      cfg_r <= CFG_RESET;
    else if (wr_ok && idx_r == IDX_TIMER_CONFIG)
      cfg_r <= wdat & CFG_WMASK;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      reload_r <= ZERO8;
      kick_r <= 1'b0;
    end
    else
    begin
      if (wr_ok && idx_r == IDX_TMR_RELOAD)
        reload_r <= wdat;
      kick_r <= wr_ok && idx_r == IDX_TMR_SERVICE;
    end
  end

  // Status bits clear on read; a new event in that cycle still sets
  always_comb
  begin
    status_nxt = status_r;
    if (rd_en && addr_ok_r && idx_r == IDX_IRQ_STATUS)
      status_nxt = ZERO8;
    if (tif.expired)
      status_nxt[STAT_TIMEOUT_BIT] = 1'b1;
    status_nxt = status_nxt & STAT_WMASK;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      status_r <= ZERO8;
      mask_r <= ZERO8;
      irq_r <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      if (wr_ok && idx_r == IDX_IRQ_MASK)
        mask_r <= wdat & STAT_WMASK;
      irq_r <= |(status_r & mask_r);
    end
  end

  assign tif.run = cfg_r[CFG_PM_BIT] && activate_r;
  assign tif.kick = kick_r;
  assign tif.reload = reload_r;

  // Low power or inactive: output parks high
  assign want_low = tif.timeout && cfg_r[CFG_PM_BIT] && activate_r;
  assign float_req = cfg_r[CFG_TRI_BIT] && !activate_r;

  timeout_timer_unit #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .mclk(mclk),
    .srst(srst),
    .tif(tif)
  );

  timeout_pin_driver u_pin (
    .mclk(mclk),
    .srst(srst),
    .want_low(want_low),
    .push_pull(cfg_r[CFG_OT_BIT]),
    .pullup_req(cfg_r[CFG_PU_BIT]),
    .float_req(float_req),
    .pin_o(timeout_pin_o),
    .pin_oe_n(timeout_pin_oe_n),
    .pullup_en(timeout_pullup_en)
  );

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = HRESP_OKAY;
  assign irq = irq_r;
  assign irq_route_sel = intsel_r[ROUTE_SEL_MSB:0];
  assign irq_wake_en = intsel_r[WAKE_BIT];
  assign irq_type_level = inttype_r;

  sequence s_read_taken;
    accept && !hwrite;
  endsequence
  sequence s_one_wait;
    !hreadyout_r ##1 hreadyout_r;
  endsequence

  a_read_wait_state: assert property (@(posedge mclk) disable iff (srst)
    s_read_taken |=> s_one_wait)
    else $error("read did not take exactly one wait state");
  a_runtime_blocked: assert property (@(posedge mclk) disable iff (srst)
    (rd_en && is_runtime(idx_r) && !activate_r) |=> hrdata_r == '0)
    else $error("runtime register readable while inactive");
  a_service_blocked: assert property (@(posedge mclk) disable iff (srst)
    ((phase_r == BUS_WRITE) && idx_r == IDX_TMR_SERVICE && !activate_r) |=> !kick_r)
    else $error("service accepted while inactive");
  a_base_high_rw: assert property (@(posedge mclk) disable iff (srst)
    (wr_ok && idx_r == IDX_BASE_HIGH) |=> base_hi_r == $past(wdat))
    else $error("base high byte not written");
  a_base_low_align: assert property (@(posedge mclk) disable iff (srst)
    (rd_en && idx_r == IDX_BASE_LOW) |=> hrdata_r[1:0] == 2'h0)
    else $error("base low bits 1:0 not zero");
  a_route_select: assert property (@(posedge mclk) disable iff (srst)
    (wr_ok && idx_r == IDX_INT_SELECT) |=> irq_route_sel == $past(wdat[ROUTE_SEL_MSB:0]))
    else $error("interrupt select not routed");
  a_int_type_ro: assert property (@(posedge mclk) disable iff (srst)
    (rd_en && addr_ok_r && idx_r == IDX_INT_TYPE) |=> (hrdata_r[7:2] == 6'h00 && hrdata_r[0]))
    else $error("interrupt type read-only bits wrong");
  a_dma_report: assert property (@(posedge mclk) disable iff (srst)
    (rd_en && addr_ok_r && (idx_r == IDX_DMA_REPORT0 || idx_r == IDX_DMA_REPORT1))
    |=> hrdata_r == {24'h000000, DMA_NONE})
    else $error("DMA report not 04h");
  a_cfg_reset: assert property (@(posedge mclk)
    srst |=> cfg_r == CFG_RESET)
    else $error("config register reset value wrong");
  a_power_off_high: assert property (@(posedge mclk) disable iff (srst)
    (!cfg_r[CFG_PM_BIT] ##1 !cfg_r[CFG_PM_BIT]) |-> (timeout_pin_oe_n || timeout_pin_o))
    else $error("timeout pin low in low power mode");
  // Inactive device cannot kick either, so the count must freeze
  a_run_gating: assert property (@(posedge mclk) disable iff (srst)
    !activate_r |=> $stable(tif.count))
    else $error("timer counted while inactive");
  a_cfg_reserved: assert property (@(posedge mclk) disable iff (srst)
    (rd_en && addr_ok_r && idx_r == IDX_TIMER_CONFIG) |=> hrdata_r[7:4] == 4'h0)
    else $error("reserved config bits not zero");
  a_status_clear: assert property (@(posedge mclk) disable iff (srst)
    (rd_en && addr_ok_r && idx_r == IDX_IRQ_STATUS && !tif.expired) |=> status_r == ZERO8)
    else $error("status not cleared by read");
  a_status_set_wins: assert property (@(posedge mclk) disable iff (srst)
    tif.expired |=> status_r[STAT_TIMEOUT_BIT])
    else $error("expiry lost against status read");
  a_wake_enable: assert property (@(posedge mclk) disable iff (srst)
    (wr_ok && idx_r == IDX_INT_SELECT) |=> irq_wake_en == $past(wdat[WAKE_BIT]))
    else $error("wake enable not stored");
  a_int_type_write: assert property (@(posedge mclk) disable iff (srst)
    (wr_ok && idx_r == IDX_INT_TYPE) |=> irq_type_level == $past(wdat[INTTYPE_LVL_BIT]))
    else $error("interrupt type bit 1 not stored");
  a_runtime_write_blocked: assert property (@(posedge mclk) disable iff (srst)
    ((phase_r == BUS_WRITE) && is_runtime(idx_r) && !activate_r) |=> $stable(reload_r))
    else $error("runtime register written while inactive");
  a_open_drain: assert property (@(posedge mclk) disable iff (srst)
    (!float_req && !cfg_r[CFG_OT_BIT]) |=> !timeout_pin_o)
    else $error("open-drain pin driven high");
  a_base_low_write: assert property (@(posedge mclk) disable iff (srst)
    (wr_ok && idx_r == IDX_BASE_LOW) |=> (base_lo_r[7:2] == $past(wdat[7:2]) && base_lo_r[1:0] == 2'h0))
    else $error("base low byte write wrong");
endmodule : timeout_timer_ldev
`default_nettype wire

/* verification/timeout_timer_ldev_bench.sv */
// Self-checking bench for the timeout timer logical device over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module timeout_timer_ldev_bench
  import timeout_cfg_pkg::*;
;
  localparam int unsigned TICKS = 4;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic [3:0] irq_route_sel;
  logic irq_wake_en;
  logic irq_type_level;
  logic timeout_pin_o;
  logic timeout_pin_oe_n;
  logic timeout_pullup_en;
  logic [7:0] pins;
  int miscompares = 0;
  int comparisons = 0;
  int n;
  logic [9:0] tbl_idx [7];
  logic [7:0] tbl_wr [7];
  logic [7:0] tbl_exp [7];

  assign pins = {5'h00, timeout_pullup_en, timeout_pin_oe_n, timeout_pin_o};

  timeout_timer_ldev #(.TICK_CYCLES(TICKS)) dut (
    .mclk(mclk),
    .srst(srst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .irq(irq),
    .irq_route_sel(irq_route_sel),
    .irq_wake_en(irq_wake_en),
    .irq_type_level(irq_type_level),
    .timeout_pin_o(timeout_pin_o),
    .timeout_pin_oe_n(timeout_pin_oe_n),
    .timeout_pullup_en(timeout_pullup_en)
  );

  always #5 mclk = ~mclk;

  function automatic logic [31:0] ba(input logic [9:0] idx);
    return {20'h00000, idx, 2'b00};
  endfunction : ba

  task automatic results;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // Every wait is bounded so a stuck slave ends the run instead of hanging
  task automatic wait_ready;
    int k;
    k = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1)
    begin
      @(posedge mclk);
      k++;
      if (k > 50)
      begin
        miscompares++;
        $display("FAIL %0t got %h exp %h", $time, hreadyout, 1'b1);
        results();
      end
    end
  endtask : wait_ready

  task automatic bus_write(input logic [31:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= 1'b1;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wait_ready();
  endtask : bus_write

  task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= 1'b0;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    wait_ready();
    d = hrdata;
  endtask : bus_read

  task automatic check_reg(input logic [31:0] a, input logic [7:0] exp);
    logic [31:0] got;
    bus_read(a, got);
    comparisons++;
    if (got !== {24'h000000, exp})
    begin
      miscompares++;
      $display("FAIL %0t addr %h got %h exp %h", $time, a, got, exp);
    end
  endtask : check_reg

  task automatic check_sig(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_sig

  task automatic idle(input int c);
    repeat (c) @(posedge mclk);
  endtask : idle

  initial
  begin
    tbl_idx = '{IDX_BASE_HIGH, IDX_BASE_LOW, IDX_INT_SELECT, IDX_INT_TYPE, IDX_DMA_REPORT0, IDX_DMA_REPORT1,
      IDX_TIMER_CONFIG};
    tbl_wr = '{8'hA5, 8'hFF, 8'h1F, 8'h00, 8'hFF, 8'h00, 8'hFF};
    tbl_exp = '{8'hA5, 8'hFC, 8'h1F, 8'h01, 8'h04, 8'h04, 8'h0F};
    idle(16);
    srst <= 1'b0;
    idle(1);
    check_sig(pins, 8'h03);
    check_sig({7'h00, irq_type_level}, 8'h01);
    check_reg(ba(IDX_ACTIVATE), 8'h00);
    check_reg(ba(IDX_BASE_HIGH), 8'h00);
    check_reg(ba(IDX_BASE_LOW), 8'h00);
    check_reg(ba(IDX_INT_SELECT), 8'h00);
    check_reg(ba(IDX_INT_TYPE), 8'h03);
    check_reg(ba(IDX_DMA_REPORT0), 8'h04);
    check_reg(ba(IDX_DMA_REPORT1), 8'h04);
    check_reg(ba(IDX_TIMER_CONFIG), 8'h02);
    for (int i = 0; i < 7; i++)
    begin
      bus_write(ba(tbl_idx[i]), tbl_wr[i]);
      check_reg(ba(tbl_idx[i]), tbl_exp[i]);
    end
    check_sig({2'b00, irq_type_level, irq_wake_en, irq_route_sel}, 8'h1F);
    // Out-of-range upper address bits must not alias onto the bank
    bus_write(32'h10000180, 8'h5A);
    check_reg(ba(IDX_BASE_HIGH), 8'hA5);
    check_reg(32'h00000800, 8'h00);
    idle(3);
    check_sig(pins, 8'h07);
    bus_write(ba(IDX_TIMER_CONFIG), 8'h0E);
    idle(3);
    check_sig(pins, 8'h05);
    bus_write(ba(IDX_TIMER_CONFIG), 8'h06);
    idle(3);
    check_sig(pins, 8'h06);
    bus_write(ba(IDX_TMR_RELOAD), 8'h05);
    check_reg(ba(IDX_TMR_RELOAD), 8'h00);
    bus_write(ba(IDX_ACTIVATE), 8'h01);
    check_reg(ba(IDX_TMR_RELOAD), 8'h00);
    bus_write(ba(IDX_TMR_RELOAD), 8'h05);
    check_reg(ba(IDX_TMR_RELOAD), 8'h05);
    bus_write(ba(IDX_TIMER_CONFIG), 8'h0A);
    bus_write(ba(IDX_TMR_SERVICE), 8'h00);
    n = 0;
    while (timeout_pin_o !== 1'b0 && n < 200)
    begin
      idle(1);
      n++;
    end
    // Five ticks of four cycles, plus prescaler phase and pin lag
    check_sig({7'h00, (n >= 5 * TICKS - 4) && (n <= 5 * TICKS + 6)}, 8'h01);
    idle(3);
    check_sig(pins, 8'h00);
    check_sig({7'h00, irq}, 8'h00);
    bus_write(ba(IDX_IRQ_MASK), 8'h01);
    idle(2);
    check_sig({7'h00, irq}, 8'h01);
    check_reg(ba(IDX_IRQ_STATUS), 8'h01);
    idle(2);
    check_sig({7'h00, irq}, 8'h00);
    check_reg(ba(IDX_IRQ_STATUS), 8'h00);
    bus_write(ba(IDX_TIMER_CONFIG), 8'h08);
    idle(3);
    check_sig(pins, 8'h01);
    bus_write(ba(IDX_TMR_SERVICE), 8'h00);
    idle(40);
    check_reg(ba(IDX_TMR_COUNT), 8'h05);
    check_reg(ba(IDX_TMR_RELOAD), 8'h05);
    bus_write(ba(IDX_TIMER_CONFIG), 8'h0A);
    idle(40);
    check_reg(ba(IDX_TMR_COUNT), 8'h00);
    check_reg(ba(IDX_IRQ_STATUS), 8'h01);
    bus_write(ba(IDX_TIMER_CONFIG), 8'h0B);
    idle(3);
    check_sig(pins, 8'h00);
    bus_write(ba(IDX_ACTIVATE), 8'h00);
    idle(3);
    check_sig(pins, 8'h03);
    check_sig({7'h00, hresp}, 8'h00);
    results();
  end
endmodule : timeout_timer_ldev_bench
`default_nettype wire
